// ===== hw/core_exc_pkg.sv
// Constants, types and register map of the exception priority unit.
// Assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
//
// Function
// - One maskable external interrupt, gated by enable bit
// - Taking any interrupt clears external enable bit, unless a state word write lands in the last entry cycle
// - Retire what can retire, then attach interrupt
// - Retire only clean moves, returns, memory, cache ops
// - Discard others; resume at first discarded one
// - Buffer fully retired: resume at next instruction
// - Latency includes pending memory access completion
// - Older instruction exception recognised before external interrupt
// - Two classes: instruction-related and asynchronous
// - Earliest detected exception suppresses later ones
// - Only oldest instruction's exception is taken
// - Order trace, fetch miss/error, check, breakpoint, emulation
// - Float, privilege, alignment, call, trap mutually exclusive
// - Privileged instruction in user mode faults
// - Then data miss, data error, data check, breakpoint
// - Trace skips one instruction, traps the second
// - Only highest priority asynchronous cause taken
// - Debug NMI, system reset, then instruction-related
// - Then peripheral break, external, decrementer lowest
// - Recognise exception when completed instruction heads queue
// - Restore within three clocks, then one-clock entry
package core_exc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  MSW_ADDR     = 8'h00;
   localparam logic [7:0]  RESUME_ADDR  = 8'h04;
   localparam logic [7:0]  SAVED_ADDR   = 8'h08;
   localparam logic [7:0]  STATUS_ADDR  = 8'h0c;

   // Machine state word fields
   localparam int          MSW_W        = 5;
   localparam int          EE_BIT       = 0;
   localparam int          FE_BIT       = 1;
   localparam int          USER_BIT     = 2;
   localparam int          TRACE_BIT    = 3;
   localparam int          RI_BIT       = 4;
   localparam logic [4:0]  MSW_RESET    = 5'h10;

   // Status register fields
   localparam int          CAUSE_LSB    = 0;
   localparam int          BUSY_BIT     = 8;

   // Detection flags of the head instruction, earliest first
   localparam int          NUM_FLAGS    = 12;
   localparam int          F_ITLB_MISS  = 0;
   localparam int          F_ITLB_ERR   = 1;
   localparam int          F_MCHK_FETCH = 2;
   localparam int          F_IBRK       = 3;
   localparam int          F_EMUL       = 4;
   localparam int          F_ALIGN      = 5;
   localparam int          F_SYSCALL    = 6;
   localparam int          F_TRAP       = 7;
   localparam int          F_DTLB_MISS  = 8;
   localparam int          F_DTLB_ERR   = 9;
   localparam int          F_MCHK_DATA  = 10;
   localparam int          F_DBRK       = 11;

   // Asynchronous request bits
   localparam int          NUM_ASYNC    = 5;
   localparam int          A_DEV_NMI    = 0;
   localparam int          A_NMI_N      = 1;
   localparam int          A_PERIPH     = 2;
   localparam int          A_EXT        = 3;
   localparam int          A_DEC        = 4;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_NS       = 100;
   localparam int          RESTORE_NS   = 300;
   localparam int          ENTRY_NS     = 100;
   localparam int          RESTORE_CYC  = (RESTORE_NS / CLK_NS < 1) ? 1 : RESTORE_NS / CLK_NS;
   localparam int          ENTRY_CYC    = (ENTRY_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CNT_W        = 3;

   typedef enum logic [4:0] {
      C_NONE       = 5'h00,
      C_TRACE      = 5'h01,
      C_ITLB_MISS  = 5'h02,
      C_ITLB_ERR   = 5'h03,
      C_MCHK_FETCH = 5'h04,
      C_IBRK       = 5'h05,
      C_EMUL       = 5'h06,
      C_FP_UNAVAIL = 5'h07,
      C_PRIV       = 5'h08,
      C_ALIGN      = 5'h09,
      C_SYSCALL    = 5'h0a,
      C_TRAP       = 5'h0b,
      C_DTLB_MISS  = 5'h0c,
      C_DTLB_ERR   = 5'h0d,
      C_MCHK_DATA  = 5'h0e,
      C_DBRK       = 5'h0f,
      C_DEV_NMI    = 5'h10,
      C_SYS_RESET  = 5'h11,
      C_PERIPH_BRK = 5'h12,
      C_EXT_IRQ    = 5'h13,
      C_DEC        = 5'h14
   } cause_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RESTORE = 2'b01,
      ST_ENTRY   = 2'b10
   } state_t;

endpackage

// ===== hw/core_exception_priority_unit.sv
// Exception acceptance and prioritisation for the core's history buffer.
// Assumes head-of-buffer flags come from same-clock pipeline logic and
// the asynchronous requests come from pins or other blocks.
`timescale 1ns/1ns
module core_exception_priority_unit (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // AHB-Lite slave
   input  wire logic                         hsel,
   input  wire logic [core_exc_pkg::ADDR_W-1:0] haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic [31:0]                       hrdata,
   // Asynchronous requests
   input  wire logic                         devNmi,
   input  wire logic                         nmiReq_n,
   input  wire logic                         periphBrk,
   input  wire logic                         extIrq,
   input  wire logic                         decReq,
   // History buffer head
   input  wire logic                         headValid,
   input  wire logic                         headDone,
   input  wire logic                         headRetirable,
   input  wire logic                         headMemBusy,
   input  wire logic                         headFloat,
   input  wire logic                         headPrivileged,
   input  wire logic [core_exc_pkg::NUM_FLAGS-1:0] headFlags,
   input  wire logic [31:0]                  headAddr,
   input  wire logic [31:0]                  nextAddr,
   // Pipeline control
   output logic                              retirePulse,
   output logic                              killPulse,
   output logic                              handlerGo,
   output core_exc_pkg::cause_t              causeOut,
   output logic [31:0]                       resumeOut,
   output logic                              extEnable,
   output logic                              userMode
);
   import core_exc_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [NUM_ASYNC-1:0] asyncRaw;
   logic [NUM_ASYNC-1:0] sync1_reg;
   logic [NUM_ASYNC-1:0] sync2_reg;

   assign asyncRaw = {decReq, extIrq, periphBrk, nmiReq_n, devNmi};

   // Low-active pin resets to its idle level: no false request
   genvar gi;
   generate
      for (gi = 0; gi < NUM_ASYNC; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               sync1_reg[gi] <= (gi == A_NMI_N);
               sync2_reg[gi] <= (gi == A_NMI_N);
            end else begin
               sync1_reg[gi] <= asyncRaw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [MSW_W-1:0] msw_reg;
   logic [MSW_W-1:0] savedMsw_reg;
   state_t           state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             traceSkip_reg;
   logic             wrPend_reg;
   logic [ADDR_W-1:0] wrAddr_reg;

   logic   ee;
   logic   inUser;
   logic   traceOn;
   assign ee      = msw_reg[EE_BIT];
   assign inUser  = msw_reg[USER_BIT];
   assign traceOn = msw_reg[TRACE_BIT];

   // ----------------------------------------------------------------
   // Instruction-related cause of the head
   // ----------------------------------------------------------------
   cause_t instCause;
   logic   fpFault;
   logic   privFault;

   assign fpFault   = headFloat && !msw_reg[FE_BIT];
   assign privFault = headPrivileged && inUser;

   // Earliest detection wins; later flags are never looked at
   always_comb begin
      instCause = C_NONE;
      if (traceOn && !traceSkip_reg) instCause = C_TRACE;
      else if (headFlags[F_ITLB_MISS])  instCause = C_ITLB_MISS;
      else if (headFlags[F_ITLB_ERR])   instCause = C_ITLB_ERR;
      else if (headFlags[F_MCHK_FETCH]) instCause = C_MCHK_FETCH;
      else if (headFlags[F_IBRK])       instCause = C_IBRK;
      else if (headFlags[F_EMUL])       instCause = C_EMUL;
      else if (fpFault)                 instCause = C_FP_UNAVAIL;
      else if (privFault)               instCause = C_PRIV;
      else if (headFlags[F_ALIGN])      instCause = C_ALIGN;
      else if (headFlags[F_SYSCALL])    instCause = C_SYSCALL;
      else if (headFlags[F_TRAP])       instCause = C_TRAP;
      else if (headFlags[F_DTLB_MISS])  instCause = C_DTLB_MISS;
      else if (headFlags[F_DTLB_ERR])   instCause = C_DTLB_ERR;
      else if (headFlags[F_MCHK_DATA])  instCause = C_MCHK_DATA;
      else if (headFlags[F_DBRK])       instCause = C_DBRK;
   end

   // ----------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------
   logic   headClean;
   logic   headExc;
   logic   maskedReq;
   logic   take;
   logic   retire;
   cause_t takeCause;
   logic [31:0] takeResume;

   // Only the head, the oldest instruction, may raise an interrupt
   assign headClean = headValid && headDone && instCause == C_NONE;
   assign headExc   = headValid && headDone && instCause != C_NONE;

   // Maskable requests stay pending as levels while disabled
   assign maskedReq = ee && (sync2_reg[A_PERIPH] || sync2_reg[A_EXT]
                             || sync2_reg[A_DEC]);

   // Decision of each idle edge, highest priority first
   always_comb begin
      take       = 1'b0;
      retire     = 1'b0;
      takeCause  = C_NONE;
      takeResume = headValid ? headAddr : nextAddr;
      if (sync2_reg[A_DEV_NMI]) begin
         take      = 1'b1;
         takeCause = C_DEV_NMI;
      end else if (!sync2_reg[A_NMI_N]) begin
         take      = 1'b1;
         takeCause = C_SYS_RESET;
      end else if (headExc) begin
         take      = 1'b1;
         takeCause = instCause;
      end else if (maskedReq) begin
         if (headClean && headRetirable) begin
            retire = 1'b1;
         end else if (headValid && headMemBusy) begin
            take = 1'b0;
         end else begin
            take = 1'b1;
            if (sync2_reg[A_PERIPH]) takeCause = C_PERIPH_BRK;
            else if (sync2_reg[A_EXT]) takeCause = C_EXT_IRQ;
            else takeCause = C_DEC;
         end
      end else if (headClean) begin
         retire = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Kill, restore count, then one entry cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 3'h0;
         retirePulse <= 1'b0;
         killPulse   <= 1'b0;
         handlerGo   <= 1'b0;
      end else begin
         retirePulse <= 1'b0;
         killPulse   <= 1'b0;
         handlerGo   <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               retirePulse <= retire;
               if (take) begin
                  killPulse <= 1'b1;
                  state_reg <= ST_RESTORE;
                  cnt_reg   <= CNT_W'(RESTORE_CYC - 1);
               end
            end
            ST_RESTORE: begin
               if (cnt_reg == 3'h0) begin
                  state_reg <= ST_ENTRY;
                  cnt_reg   <= CNT_W'(ENTRY_CYC - 1);
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            ST_ENTRY: begin
               if (cnt_reg == 3'h0) begin
                  handlerGo <= 1'b1;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Cause and resume point of the interrupt being taken
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         causeOut     <= C_NONE;
         resumeOut    <= 32'h0;
         savedMsw_reg <= MSW_RESET;
      end else if (state_reg == ST_IDLE && take) begin
         causeOut     <= takeCause;
         resumeOut    <= takeResume;
         savedMsw_reg <= msw_reg;
      end
   end

   // Trace lets the first instruction pass untraced
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         traceSkip_reg <= 1'b1;
      end else if (!traceOn) begin
         traceSkip_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && retire) begin
         traceSkip_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Machine state word
   // ----------------------------------------------------------------
   logic entryLast;
   logic mswWrite;

   assign entryLast = state_reg == ST_ENTRY && cnt_reg == 3'h0;
   assign mswWrite  = wrPend_reg && wrAddr_reg == MSW_ADDR;

   // A bus write in the last entry cycle beats the hardware clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         msw_reg <= MSW_RESET;
      end else if (mswWrite) begin
         msw_reg <= hwdata[MSW_W-1:0];
      end else if (entryLast) begin
         msw_reg[EE_BIT]    <= 1'b0;
         msw_reg[USER_BIT]  <= 1'b0;
         msw_reg[TRACE_BIT] <= 1'b0;
      end
   end

   // Registered copies for the pipeline
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         extEnable <= 1'b0;
         userMode  <= 1'b0;
      end else begin
         extEnable <= ee;
         userMode  <= inUser;
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   logic        addrPhase;
   logic [31:0] readMux;

   assign addrPhase = hsel && htrans[1] && hready;

   // Read data are selected in the address phase
   always_comb begin
      readMux = 32'h0;
      unique case (haddr)
         MSW_ADDR:    readMux[MSW_W-1:0] = msw_reg;
         RESUME_ADDR: readMux = resumeOut;
         SAVED_ADDR:  readMux[MSW_W-1:0] = savedMsw_reg;
         STATUS_ADDR: begin
            readMux[CAUSE_LSB +: 5] = causeOut;
            readMux[BUSY_BIT]       = state_reg != ST_IDLE;
         end
         default:     readMux = 32'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Read forwarding
   // ----------------------------------------------------------------
   // A state word read right behind a state word write has its address
   // phase in the write's data phase, before the write lands: hand it
   // the word being written instead of the old one
   logic        fwdMsw;
   logic [31:0] readWord;

   assign fwdMsw = mswWrite && haddr == MSW_ADDR;

   always_comb begin
      readWord = readMux;
      if (fwdMsw) begin
         readWord            = 32'h0;
         readWord[MSW_W-1:0] = hwdata[MSW_W-1:0];
      end
   end

   // Write data follow one cycle after the address
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= '0;
      end else begin
         wrPend_reg <= addrPhase && hwrite;
         wrAddr_reg <= haddr;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0;
      end else if (addrPhase && !hwrite) begin
         hrdata <= readWord;
      end
   end

   // Zero wait states; the response is always OKAY
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule // core_exception_priority_unit

// ===== tb/core_exc_checker.sv
// Concurrent checks on the exception priority unit's ports.
// Assumes the unit's single clock and synchronous active-low reset.
`timescale 1ns/1ns
module core_exc_checker (
   input wire logic                             clk, rst_n, hsel, hwrite, hready,
   input wire logic                             devNmi, extIrq, headValid, headDone,
   input wire logic [core_exc_pkg::ADDR_W-1:0]    haddr,
   input wire logic [1:0]                       htrans,
   input wire logic [core_exc_pkg::NUM_FLAGS-1:0] headFlags,
   input wire logic [31:0]                      headAddr, nextAddr, resumeOut,
   input wire logic                             retirePulse, killPulse, handlerGo,
   input core_exc_pkg::cause_t                  causeOut,
   input wire logic                             extEnable, userMode
);
   import core_exc_pkg::*;
   logic mswWr;
   // ----------------------------------------
   // Data phase of a state word write
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mswWr <= 1'b0;
      end else begin
         mswWr <= hsel && htrans[1] && hready && hwrite && haddr == MSW_ADDR;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_entry;
      (!handlerGo)[*3] ##1 handlerGo;
   endsequence
   sequence s_quiet;
      (!killPulse)[*4];
   endsequence
   a_entry_delay: assert property (killPulse |=> s_entry)
      else $error("handler entry not four cycles after kill");
   a_kill_spacing: assert property (killPulse |=> s_quiet)
      else $error("second kill while busy");
   a_entry_clears: assert property (handlerGo && !$past(mswWr) |=> !extEnable && !userMode)
      else $error("entry left enable or user set");
   a_masked_wait: assert property (killPulse && causeOut inside {C_EXT_IRQ, C_DEC,
      C_PERIPH_BRK} |-> extEnable)
      else $error("maskable cause taken while disabled");
   a_nmi_first: assert property (killPulse && $past(devNmi, 3)
      |-> causeOut == C_DEV_NMI)
      else $error("debug nmi not taken first");
   a_ext_over_dec: assert property (killPulse && extEnable && $past(extIrq, 3)
      |-> causeOut != C_DEC)
      else $error("decrementer beat external request");
   a_retire_clean: assert property (retirePulse |->
      $past(headValid && headDone && headFlags == '0))
      else $error("retired an unclean head");
   a_resume_head: assert property (killPulse && $past(headValid) |->
      resumeOut == $past(headAddr))
      else $error("resume not at head");
   a_resume_next: assert property (killPulse && !$past(headValid) |->
      resumeOut == $past(nextAddr))
      else $error("resume not at next address");
endmodule // core_exc_checker

bind core_exception_priority_unit core_exc_checker chk (.clk(clk), .rst_n(rst_n),
   .hsel(hsel), .hwrite(hwrite), .hready(hready), .devNmi(devNmi), .extIrq(extIrq),
   .headValid(headValid), .headDone(headDone), .haddr(haddr), .htrans(htrans),
   .headFlags(headFlags), .headAddr(headAddr), .nextAddr(nextAddr),
   .resumeOut(resumeOut), .retirePulse(retirePulse), .killPulse(killPulse),
   .handlerGo(handlerGo), .causeOut(causeOut), .extEnable(extEnable),
   .userMode(userMode));

// ===== tb/core_exception_priority_unit_tb.sv
// Self-checking bench for the exception priority unit.
// Assumes a 10 MHz clock and the register map of the unit's package.
`timescale 1ns/1ns
module core_exception_priority_unit_tb;
   import core_exc_pkg::*;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, devNmi, nmiReq_n, periphBrk;
   logic extIrq, decReq, headValid, headDone, headRetirable, headMemBusy, headFloat;
   logic headPrivileged, retirePulse, killPulse, handlerGo, extEnable, userMode, raise, ack;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [11:0] headFlags;
   logic [31:0] hwdata, hrdata, headAddr, nextAddr, resumeOut, d;
   cause_t      causeOut;
   int          mismatches, checkCount, retires;
   core_exception_priority_unit DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .devNmi(devNmi),
      .nmiReq_n(nmiReq_n), .periphBrk(periphBrk), .extIrq(extIrq), .decReq(decReq),
      .headValid(headValid), .headDone(headDone), .headRetirable(headRetirable),
      .headMemBusy(headMemBusy), .headFloat(headFloat), .headPrivileged(headPrivileged),
      .headFlags(headFlags), .headAddr(headAddr), .nextAddr(nextAddr),
      .retirePulse(retirePulse), .killPulse(killPulse), .handlerGo(handlerGo),
      .causeOut(causeOut), .resumeOut(resumeOut), .extEnable(extEnable), .userMode(userMode));
   intc_model intc (.clk(clk), .rst_n(rst_n), .raise(raise), .ack(ack), .extIrq(extIrq));
   // ----------------------------------------
   // Clock, watchdog and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      giveVerdict();
   end
   always @(negedge clk) if (retirePulse === 1'b1) retires++;
   task automatic giveVerdict();
      if (mismatches == 0 && checkCount > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic busCycle(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00; hsel <= 1'b0; hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic head(input logic v, input logic r, input logic [11:0] f);
      @(posedge clk);
      headValid <= v; headDone <= v; headRetirable <= r; headFlags <= f;
   endtask
   task automatic ext();
      @(posedge clk);
      raise <= 1'b1; ack <= 1'b0;
      @(posedge clk);
      raise <= 1'b0;
   endtask
   task automatic quiet(input int n);
      repeat (n) @(negedge clk) chk(killPulse, 0);
   endtask
   // Wait for a take, check it, drop every source, wait for entry
   task automatic take(input cause_t c, input logic [31:0] r);
      int n;
      n = 0;
      do begin @(negedge clk); n++; end while (killPulse !== 1'b1 && n < 60);
      chk(killPulse, 1);
      chk(causeOut, c);
      chk(resumeOut, r);
      @(posedge clk);
      devNmi <= 1'b0; nmiReq_n <= 1'b1; periphBrk <= 1'b0; decReq <= 1'b0; ack <= 1'b1;
      headValid <= 1'b0; headMemBusy <= 1'b0; headFloat <= 1'b0; headPrivileged <= 1'b0;
      n = 0;
      while (handlerGo !== 1'b1 && n < 10) begin @(negedge clk); n++; end
      chk(n, 4);
      repeat (4) @(posedge clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic tMasked();
      busCycle(MSW_ADDR, 0, 0); chk(d, 32'h10);
      busCycle(8'h40, 0, 0); chk(d, 0);
      head(1, 0, 0); ext(); quiet(20);
      busCycle(MSW_ADDR, 1, 32'h11); take(C_EXT_IRQ, 32'h100);
      busCycle(STATUS_ADDR, 0, 0); chk(d, 32'(C_EXT_IRQ));
      busCycle(RESUME_ADDR, 0, 0); chk(d, 32'h100);
      busCycle(SAVED_ADDR, 0, 0); chk(d, 32'h11);
      busCycle(MSW_ADDR, 0, 0); chk(d & 1, 0);
      chk(extEnable, 0);
      chk(hresp, 0);
   endtask
   task automatic tRetire();
      int r0;
      busCycle(MSW_ADDR, 1, 32'h11); r0 = retires;
      head(1, 1, 0); ext(); quiet(8);
      chk(retires > r0, 1);
      head(0, 0, 0); take(C_EXT_IRQ, 32'h200);
   endtask
   task automatic tMemWait();
      busCycle(MSW_ADDR, 1, 32'h11); head(1, 0, 0); headMemBusy <= 1'b1;
      ext(); quiet(15);
      @(posedge clk); headMemBusy <= 1'b0; take(C_EXT_IRQ, 32'h100);
   endtask
   task automatic tPrio();
      cause_t e[6] = '{C_DEV_NMI, C_SYS_RESET, C_ALIGN, C_PERIPH_BRK, C_EXT_IRQ, C_DEC};
      for (int i = 0; i < 6; i++) begin
         busCycle(MSW_ADDR, 1, 32'h11);
         if (i < 5) ext();
         devNmi <= i < 1; nmiReq_n <= !(i < 2); periphBrk <= i < 4; decReq <= 1'b1;
         // Head arrives at the decision that first sees the synced requests
         @(posedge clk);
         head(i < 3, 0, (i < 3) ? 12'h020 : 12'h000);
         take(e[i], (i < 3) ? 32'h100 : 32'h200);
      end
   endtask
   task automatic tDetect();
      for (int b = 0; b < 12; b++) begin
         busCycle(MSW_ADDR, 1, 32'h11); head(1, 0, 12'hfff << b);
         take(cause_t'(5'((b < 5) ? b + 2 : b + 4)), 32'h100);
      end
      busCycle(MSW_ADDR, 1, 32'h11); headFloat <= 1'b1; head(1, 0, 0);
      take(C_FP_UNAVAIL, 32'h100);
      busCycle(MSW_ADDR, 1, 32'h15); headPrivileged <= 1'b1; head(1, 0, 0);
      take(C_PRIV, 32'h100);
   endtask
   task automatic tTrace();
      int r0;
      busCycle(MSW_ADDR, 1, 32'h19); r0 = retires; head(1, 1, 0);
      take(C_TRACE, 32'h100);
      chk(retires - r0, 1);
   endtask
   initial begin
      {hsel, hwrite, devNmi, periphBrk, decReq, headValid, headDone, raise, ack} = '0;
      {headRetirable, headMemBusy, headFloat, headPrivileged} = '0;
      nmiReq_n = 1'b1; haddr = 8'h00; htrans = 2'b00; hsize = 3'b010; hwdata = '0;
      headFlags = '0; headAddr = 32'h100; nextAddr = 32'h200; rst_n = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tMasked(); tRetire(); tMemWait(); tPrio(); tDetect(); tTrace();
      giveVerdict();
   end
endmodule // core_exception_priority_unit_tb

// ===== tb/intc_model.sv
// Interrupt controller model driving the external request line.
// Assumes the bench pulses raise and holds ack once serviced.
`timescale 1ns/1ns
module intc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench control
   input wire logic raise,
   input wire logic ack,
   // Request line
   output logic     extIrq
);
   // Level held until software acknowledge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         extIrq <= 1'b0;
      end else if (raise) begin
         extIrq <= 1'b1;
      end else if (ack) begin
         extIrq <= 1'b0;
      end
   end
endmodule // intc_model
